// ---- hspo_map.svh ----
`ifndef HSPO_MAP_SVH
`define HSPO_MAP_SVH

// ==========================================================
// register offsets (byte addresses on the register bus)
`define HSPO_ADDR_W 8
`define HSPO_OFF_PORT 8'h00
`define HSPO_OFF_CAPS 8'h04
`define HSPO_OFF_ROUTE 8'h08
`define HSPO_OFF_INT_STATUS 8'h0C
`define HSPO_OFF_INT_MASK 8'h10

// ==========================================================
// field positions of the port register
`define HSPO_IND_LSB 14
`define HSPO_HANDOVER_BIT 13
`define HSPO_POWER_BIT 12
`define HSPO_LINE_LSB 10
`define HSPO_ENABLE_BIT 2
`define HSPO_CONNECT_BIT 0

// field positions of the capability and routing registers
`define HSPO_IND_CAP_BIT 0
`define HSPO_PSW_CAP_BIT 1
`define HSPO_CONFIGURED_BIT 0

// interrupt status and mask bits
`define HSPO_INT_W 3
`define HSPO_INT_OVERCURRENT 0
`define HSPO_INT_LINE_CHANGE 1
`define HSPO_INT_HANDOVER 2

// ==========================================================
// reset values
`define HSPO_IND_RST 2'h0
`define HSPO_HANDOVER_RST 1'b1
`define HSPO_POWER_RST 1'b0
`define HSPO_CAPS_RST 2'h3
`define HSPO_ROUTE_RST 1'b0
`define HSPO_INT_MASK_RST 3'h0

// bus responses
`define HSPO_RESP_OKAY 2'h0
`define HSPO_RESP_SLVERR 2'h2

`endif

// ---- hspo_pkg.sv ----
`default_nettype none

package hspo_pkg;

  // indicator colour codes, in field order
  typedef enum logic [1:0] {
    HSPO_LED_OFF,
    HSPO_LED_AMBER,
    HSPO_LED_GREEN,
    HSPO_LED_UNDEF
  } hspo_led_t;

  // the port fields this block owns, in register bit order 15..10
  typedef struct packed {
    hspo_led_t indicator;
    logic handover;
    logic power;
    logic [1:0] line_state;
  } hspo_portsc_t;

endpackage

`default_nettype wire

// ---- hspo_port.sv ----
// What this block does
// - port indicator select writes are dropped while indicator capability is zero
// - with capability, indicator select 00 off, 01 amber, 10 green, 11 undefined
// - handover flag resets to one and clears when Configured rises
// - handover flag held at one while Configured is zero, beating writes
// - handover flag one routes the port to the companion controller
// - without power switch capability the port is always powered, power bit reads one
// - with power switch capability the power bit drives the switch, zero off
// - unpowered port is nonfunctional and reports no status changes; a handover flag change still sets its interrupt status bit
// - overcurrent on a powered switched port may clear the power bit
// - line-state field shows D+ in bit 11 and D- in bit 10
// - line state valid only when port disabled and device connected
// - line state is undefined while the port is unpowered
//
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/1ns
`include "hspo_map.svh"
`default_nettype none

module hspo_port (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`HSPO_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`HSPO_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic line_dp,
  input wire logic line_dm,
  input wire logic overcurrent,
  input wire logic port_enable,
  input wire logic connect_status,
  output logic port_power_en,
  output logic companion_owns,
  output logic port_functional,
  output logic led_amber,
  output logic led_green,
  output logic irq
);

  // ==========================================================
  // register bus: write path
  logic awready_r, wready_r, bvalid_r, aw_have_r, w_have_r;
  logic [1:0] bresp_r;
  logic [`HSPO_ADDR_W-1:0] aw_addr_r;
  logic [31:0] w_data_r, wmask;
  logic [3:0] w_strb_r;
  logic aw_take, w_take, do_write, aw_have_nxt, w_have_nxt, bvalid_nxt;
  logic wr_port, wr_caps, wr_route, wr_mask, wr_mapped;

  assign aw_take = awready_r & s_axi_awvalid;
  assign w_take = wready_r & s_axi_wvalid;
  // the write lands one cycle after both halves are held, in either order
  assign do_write = aw_have_r & w_have_r;
  assign aw_have_nxt = (aw_have_r | aw_take) & ~do_write;
  assign w_have_nxt = (w_have_r | w_take) & ~do_write;
  assign bvalid_nxt = do_write | (bvalid_r & ~s_axi_bready);

  assign wr_port = do_write & (aw_addr_r == `HSPO_OFF_PORT);
  assign wr_caps = do_write & (aw_addr_r == `HSPO_OFF_CAPS);
  assign wr_route = do_write & (aw_addr_r == `HSPO_OFF_ROUTE);
  assign wr_mask = do_write & (aw_addr_r == `HSPO_OFF_INT_MASK);
  // the status register is read-to-clear; writes to it are accepted and ignored
  assign wr_mapped = wr_port | wr_caps | wr_route | wr_mask |
                     (aw_addr_r == `HSPO_OFF_INT_STATUS);

  for (genvar i = 0; i < 4; i++) begin : g_strb
    assign wmask[i*8 +: 8] = {8{w_strb_r[i]}};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
    end else begin
      aw_have_r <= aw_have_nxt;
      w_have_r <= w_have_nxt;
      awready_r <= ~aw_have_nxt & ~bvalid_nxt;
      wready_r <= ~w_have_nxt & ~bvalid_nxt;
      bvalid_r <= bvalid_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_r <= '0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      bresp_r <= `HSPO_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_addr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (do_write) begin
        bresp_r <= wr_mapped ? `HSPO_RESP_OKAY : `HSPO_RESP_SLVERR;
      end
    end
  end

  // ==========================================================
  // line inputs: two-stage synchronisers, then the field stage
  logic [2:0] sync1_r, sync2_r;
  logic [1:0] line_r;
  logic oc_s;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
      line_r <= 2'h0;
    end else begin
      sync1_r <= {overcurrent, line_dp, line_dm};
      sync2_r <= sync1_r;
      line_r <= sync2_r[1:0];
    end
  end

  assign oc_s = sync2_r[2];

  // ==========================================================
  // capability, routing and mask registers
  logic ind_cap_r, psw_cap_r, configured_r, configured_prev_r;
  logic [`HSPO_INT_W-1:0] int_mask_r;
  logic [31:0] port_word, port_merged;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {psw_cap_r, ind_cap_r} <= `HSPO_CAPS_RST;
      configured_r <= `HSPO_ROUTE_RST;
      configured_prev_r <= `HSPO_ROUTE_RST;
      int_mask_r <= `HSPO_INT_MASK_RST;
    end else begin
      configured_prev_r <= configured_r;
      if (wr_caps && w_strb_r[0]) begin
        ind_cap_r <= w_data_r[`HSPO_IND_CAP_BIT];
        psw_cap_r <= w_data_r[`HSPO_PSW_CAP_BIT];
      end
      if (wr_route && w_strb_r[0]) begin
        configured_r <= w_data_r[`HSPO_CONFIGURED_BIT];
      end
      if (wr_mask && w_strb_r[0]) begin
        int_mask_r <= w_data_r[`HSPO_INT_W-1:0];
      end
    end
  end

  // ==========================================================
  // port fields
  hspo_pkg::hspo_led_t ind_r;
  logic handover_r, power_r, handover_nxt, power_nxt, power_eff, oc_hit;
  hspo_pkg::hspo_portsc_t portsc;

  // a switchless port is hardwired on and shows one
  assign power_eff = psw_cap_r ? power_r : 1'b1;
  // overcurrent only acts on a switched port that is on
  assign oc_hit = psw_cap_r & power_r & oc_s;

  assign portsc.indicator = ind_r;
  assign portsc.handover = handover_r;
  assign portsc.power = power_eff;
  // an unpowered port has no meaningful levels, so it reads zero
  assign portsc.line_state = power_eff ? line_r : 2'h0;
  assign port_word = ({16'h0000, portsc, 10'h000}) |
                     (32'(port_enable) << `HSPO_ENABLE_BIT) |
                     (32'(connect_status) << `HSPO_CONNECT_BIT);
  assign port_merged = (port_word & ~wmask) | (w_data_r & wmask);

  always_comb begin
    handover_nxt = handover_r;
    if (!configured_r) begin
      handover_nxt = 1'b1;
    end else if (!configured_prev_r) begin
      handover_nxt = 1'b0;
    end else if (wr_port) begin
      handover_nxt = port_merged[`HSPO_HANDOVER_BIT];
    end
  end

  always_comb begin
    power_nxt = power_r;
    if (!psw_cap_r) begin
      power_nxt = 1'b1;
    end else if (oc_hit) begin
      power_nxt = 1'b0;
    end else if (wr_port) begin
      power_nxt = port_merged[`HSPO_POWER_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ind_r <= hspo_pkg::hspo_led_t'(`HSPO_IND_RST);
      handover_r <= `HSPO_HANDOVER_RST;
      power_r <= `HSPO_POWER_RST;
    end else begin
      if (wr_port && ind_cap_r) begin
        ind_r <= hspo_pkg::hspo_led_t'(port_merged[`HSPO_IND_LSB +: 2]);
      end
      handover_r <= handover_nxt;
      power_r <= power_nxt;
    end
  end

  // ==========================================================
  // port side outputs, registered from the same next values; the indicator lights from ind_r
  logic power_en_r, companion_r, functional_r, amber_r, green_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_en_r <= 1'b0;
      companion_r <= `HSPO_HANDOVER_RST;
      functional_r <= 1'b0;
      amber_r <= 1'b0;
      green_r <= 1'b0;
    end else begin
      power_en_r <= power_nxt;
      companion_r <= handover_nxt;
      functional_r <= power_nxt;
      // undefined code lights nothing; no capability lights nothing
      amber_r <= ind_cap_r && (ind_r == hspo_pkg::HSPO_LED_AMBER);
      green_r <= ind_cap_r && (ind_r == hspo_pkg::HSPO_LED_GREEN);
    end
  end

  // ==========================================================
  // interrupt status: sticky, cleared by read, set beats clear
  logic [`HSPO_INT_W-1:0] int_status_r, int_event, int_status_nxt;
  logic irq_r, ar_take, rd_status;

  // line changes only count when the state is meaningful and powered
  assign int_event[`HSPO_INT_LINE_CHANGE] = power_eff & ~port_enable & connect_status &
                                            (sync2_r[1:0] != line_r);
  assign int_event[`HSPO_INT_OVERCURRENT] = oc_hit;
  assign int_event[`HSPO_INT_HANDOVER] = handover_nxt != handover_r;

  assign ar_take = s_axi_arready & s_axi_arvalid;
  assign rd_status = ar_take & (s_axi_araddr == `HSPO_OFF_INT_STATUS);
  assign int_status_nxt = (rd_status ? '0 : int_status_r) | int_event;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_status_r <= '0;
      irq_r <= 1'b0;
    end else begin
      int_status_r <= int_status_nxt;
      irq_r <= |(int_status_nxt & int_mask_r);
    end
  end

  // ==========================================================
  // register bus: read path
  logic arready_r, rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  assign rvalid_nxt = ar_take | (rvalid_r & ~s_axi_rready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `HSPO_RESP_OKAY;
    end else begin
      arready_r <= ~rvalid_nxt;
      rvalid_r <= rvalid_nxt;
      if (ar_take) begin
        rresp_r <= `HSPO_RESP_OKAY;
        case (s_axi_araddr)
          `HSPO_OFF_PORT: begin
            rdata_r <= port_word;
          end
          `HSPO_OFF_CAPS: begin
            rdata_r <= {30'h0000_0000, psw_cap_r, ind_cap_r};
          end
          `HSPO_OFF_ROUTE: begin
            rdata_r <= {31'h0000_0000, configured_r};
          end
          `HSPO_OFF_INT_STATUS: begin
            rdata_r <= {29'h0000_0000, int_status_r};
          end
          `HSPO_OFF_INT_MASK: begin
            rdata_r <= {29'h0000_0000, int_mask_r};
          end
          default: begin
            rdata_r <= 32'h0000_0000;
            rresp_r <= `HSPO_RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // output wiring
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign port_power_en = power_en_r;
  assign companion_owns = companion_r;
  assign port_functional = functional_r;
  assign led_amber = amber_r;
  assign led_green = green_r;
  assign irq = irq_r;

endmodule // hspo_port

`default_nettype wire

// ---- hspo_port_chk.sv ----
`timescale 1ns/1ns
`default_nettype none

module hspo_port_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic port_power_en,
  input wire logic companion_owns,
  input wire logic port_functional,
  input wire logic led_amber,
  input wire logic led_green,
  input wire logic irq
);
  // ==========================================================
  // bus and port relations
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  wr_answer_a: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("write response not two cycles after handshake");
  rd_answer_a: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read data not one cycle after address");
  aw_refused_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  ar_refused_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  b_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released");
  r_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data not released");
  func_power_a: assert property (port_functional == port_power_en)
    else $error("functional flag differs from power");
  led_excl_a: assert property (!(led_amber && led_green))
    else $error("two indicator colours lit");
  owner_reset_a: assert property ($rose(aresetn) |-> companion_owns)
    else $error("handover flag not one after reset");
  power_reset_a: assert property ($rose(aresetn) |-> !port_power_en && !irq)
    else $error("power or irq set after reset");
endmodule // hspo_port_chk

bind hspo_port hspo_port_chk u_chk (.*);

`default_nettype wire

// ---- hspo_usb_dev.sv ----
`timescale 1ns/1ns
`default_nettype none

module hspo_usb_dev (
  input wire logic aclk,
  input wire logic powered,
  input wire logic [1:0] ls,
  input wire logic oc,
  output logic line_dp,
  output logic line_dm,
  output logic overcurrent
);
  // ==========================================================
  // unpowered device: host pull-downs take both lines low
  always_ff @(posedge aclk) begin
    line_dp <= powered & ls[1];
    line_dm <= powered & ls[0];
    overcurrent <= powered & oc;
  end
endmodule // hspo_usb_dev

`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/1ns
`include "hspo_map.svh"
`default_nettype none

module testbench;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, line_dp, line_dm, overcurrent, port_enable, connect_status, oc;
  logic port_power_en, companion_owns, port_functional, led_amber, led_green, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, ls;
  int failures, num_checks;

  hspo_port u_dut (.*);
  hspo_usb_dev u_dev (.aclk(aclk), .powered(port_power_en), .ls(ls), .oc(oc),
    .line_dp(line_dp), .line_dm(line_dm), .overcurrent(overcurrent));

  // ==========================================================
  // shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // bready and rready stay high for the whole run
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    // each channel is released at the edge that takes it
    do begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end while (!(aw_done && w_done));
    do @(posedge aclk); while (!s_axi_bvalid);
  endtask

  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset;
    rd(`HSPO_OFF_PORT);
    chk(rv, 32'h0000_2000);
    rd(8'h40);
    chk({30'h0, rr}, 32'h2);
  endtask

  task automatic t_owner;
    wr(`HSPO_OFF_PORT, 32'h0);
    rd(`HSPO_OFF_PORT);
    chk(rv, 32'h0000_2000);
    wr(`HSPO_OFF_ROUTE, 32'h1);
    rd(`HSPO_OFF_PORT);
    chk(rv, 32'h0);
    chk({31'h0, companion_owns}, 32'h0);
    wr(`HSPO_OFF_PORT, 32'h0000_2000);
    rd(`HSPO_OFF_PORT);
    chk({31'h0, companion_owns}, 32'h1);
    wr(`HSPO_OFF_PORT, 32'h0);
    wr(`HSPO_OFF_ROUTE, 32'h0);
    rd(`HSPO_OFF_PORT);
    chk(rv, 32'h0000_2000);
  endtask

  task automatic t_power;
    wr(`HSPO_OFF_PORT, 32'h0000_3000);
    rd(`HSPO_OFF_PORT);
    chk({30'h0, port_power_en, port_functional}, 32'h3);
    wr(`HSPO_OFF_PORT, 32'h0000_2000);
    rd(`HSPO_OFF_PORT);
    chk({30'h0, port_power_en, port_functional}, 32'h0);
    wr(`HSPO_OFF_CAPS, 32'h1);
    rd(`HSPO_OFF_PORT);
    chk(rv & 32'h0000_1000, 32'h0000_1000);
    chk({31'h0, port_power_en}, 32'h1);
    wr(`HSPO_OFF_CAPS, 32'h3);
  endtask

  task automatic t_ind;
    for (int i = 0; i < 4; i++) begin
      wr(`HSPO_OFF_PORT, (32'(i) << 14) | 32'h0000_3000);
      rd(`HSPO_OFF_PORT);
      chk({30'h0, led_green, led_amber}, (i == 3) ? 32'h0 : 32'(i));
    end
    // without the capability the field keeps its last code
    wr(`HSPO_OFF_CAPS, 32'h2);
    wr(`HSPO_OFF_PORT, 32'h0000_7000);
    rd(`HSPO_OFF_PORT);
    chk(rv & 32'h0000_C000, 32'h0000_C000);
    wr(`HSPO_OFF_CAPS, 32'h3);
    wr(`HSPO_OFF_PORT, 32'h0000_3000);
  endtask

  task automatic t_line;
    port_enable <= 1'b0;
    connect_status <= 1'b1;
    wr(`HSPO_OFF_INT_MASK, 32'h2);
    rd(`HSPO_OFF_INT_STATUS);
    for (int i = 0; i < 4; i++) begin
      ls <= i[1:0];
      repeat (4) @(posedge aclk);
      rd(`HSPO_OFF_PORT);
      chk(rv & 32'h0000_0C00, 32'(i) << 10);
    end
    chk({31'h0, irq}, 32'h1);
    rd(`HSPO_OFF_INT_STATUS);
    chk(rv & 32'h0000_0002, 32'h0000_0002);
    rd(`HSPO_OFF_PORT);
    chk({31'h0, irq}, 32'h0);
    wr(`HSPO_OFF_PORT, 32'h0000_2000);
    repeat (4) @(posedge aclk);
    rd(`HSPO_OFF_PORT);
    chk(rv & 32'h0000_0C00, 32'h0);
  endtask

  // software finds a K-state and hands the port to the companion
  task automatic t_lowspd;
    wr(`HSPO_OFF_PORT, 32'h0000_3000);
    wr(`HSPO_OFF_ROUTE, 32'h1);
    ls <= 2'b01;
    repeat (4) @(posedge aclk);
    rd(`HSPO_OFF_PORT);
    chk(rv & 32'h0000_2C00, 32'h0000_0400);
    if (rv[11:10] == 2'b01) wr(`HSPO_OFF_PORT, 32'h0000_3000);
    chk({31'h0, companion_owns}, 32'h1);
    wr(`HSPO_OFF_ROUTE, 32'h0);
  endtask

  task automatic t_oc;
    wr(`HSPO_OFF_PORT, 32'h0000_3000);
    wr(`HSPO_OFF_INT_MASK, 32'h1);
    rd(`HSPO_OFF_INT_STATUS);
    oc <= 1'b1;
    repeat (8) if (port_power_en) @(posedge aclk);
    chk({31'h0, port_power_en}, 32'h0);
    rd(`HSPO_OFF_PORT);
    chk(rv & 32'h0000_1000, 32'h0);
    chk({31'h0, irq}, 32'h1);
    oc <= 1'b0;
    rd(`HSPO_OFF_INT_STATUS);
    chk(rv & 32'h0000_0001, 32'h1);
  endtask

  // ==========================================================
  // run control
  task automatic give_verdict;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // all scenarios finish well inside a few thousand cycles
  initial begin
    #100000;
    failures++;
    give_verdict;
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, oc} = 5'h0;
    {port_enable, connect_status, ls, s_axi_awaddr, s_axi_araddr} = 20'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset;
    t_owner;
    t_power;
    t_ind;
    t_line;
    t_oc;
    t_lowspd;
    give_verdict;
  end
endmodule // testbench

`default_nettype wire
